// *** src/rss_pkg.sv ***
/*
 * Shared constants for the read sync sequencer: input sync bit layout,
 * sequencer states, edge counts, preamble thresholds and timing counts.
 * Assumes a 40 MHz core clock and an oscillator near 8 MHz on its own port.
 */
// How it works
// RQ1: freeze oscillator at second falling clock edge
// RQ2: restart oscillator on second rising pulse
// RQ3: reference restart begins within four reference cycles
// RQ4: clock held high while frozen for restart
// RQ5: 1T pattern raises found after 34 pulses
// RQ6: 2T pattern raises found after 33 pulses
// RQ7: 3T pattern raises found after 32 pulses
// RQ8: 4T pattern raises found after 16 pulses
// RQ9: found flag rises with a clock fall
// RQ10: strobe offset is signed five bit value
// RQ11: retimed data changes only at clock falls
// RQ12: reference passes to clock while idle
// RQ13: shift on falling shift clock when enabled
// RQ14: control bit five selects test mode
// RQ15: found stays high until read withdrawn
// RQ16: broken pulse spacing restarts the run
// RQ17: idle clears strobe offset and found flag
package rss_pkg;
    // input synchroniser vector layout
    localparam int SI_READ  = 0;
    localparam int SI_PULSE = 1;
    localparam int SI_REF   = 2;
    localparam int SI_SHCLK = 3;
    localparam int SI_SHDAT = 4;
    localparam int SI_SHEN  = 5;
    localparam int SI_OSC   = 6;
    localparam int SI_SEL   = 7;
    localparam int SYNC_W   = 9;

    // control register layout
    localparam int CTL_W        = 6;
    localparam int CTL_SIGN_BIT = 4;
    localparam int CTL_TEST_BIT = 5;
    localparam int STROBE_W     = 5;
    localparam int STROBE_STEP_PERMILLE = 18;  // 1.8 % of reference period per step

    // sequence edge counts
    localparam logic [3:0] STOP_EDGES    = 4'h2;
    localparam logic [3:0] RESTART_EDGES = 4'h2;
    localparam logic [3:0] ABORT_EDGES   = 4'h2;
    localparam logic [3:0] ABORT_MAX     = 4'h4;

    // rest period in oscillator periods: half to three
    localparam int CORE_PERIOD_NS = 25;
    localparam int OSC_PERIOD_NS  = 125;
    localparam int HOLD_MIN_CYC   = (OSC_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
    localparam int HOLD_MAX_CYC   = (3 * OSC_PERIOD_NS) / CORE_PERIOD_NS;
    localparam logic [3:0] HOLD_CYC = 4'(HOLD_MIN_CYC);

    // preamble run lengths, nominal figure per pattern
    localparam logic [5:0] RUN_1T = 6'h22;
    localparam logic [5:0] RUN_2T = 6'h21;
    localparam logic [5:0] RUN_3T = 6'h20;
    localparam logic [5:0] RUN_4T = 6'h10;
    localparam logic [5:0] RUN_MAX = 6'h3F;

    localparam int FIFO_W = 1;
    localparam int FIFO_D = 16;

    typedef enum logic [5:0] {
        ST_REF       = 6'h01,
        ST_WAIT_STOP = 6'h02,
        ST_FROZEN_RD = 6'h04,
        ST_READ      = 6'h08,
        ST_ABORT     = 6'h10,
        ST_HOLD_REF  = 6'h20
    } rss_state_t;
endpackage

// *** src/rss_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on the same clock as the sequencer core.
 */
`timescale 1ns/1ps
module rss_fifo #(
    parameter int W = 1,
    parameter int D = 16
) (
    input  wire logic         i_clk,       // core clock
    input  wire logic         i_rst_n,     // async reset, low
    input  wire logic         i_in_valid,  // write request
    output logic              o_in_ready,  // space available
    input  wire logic [W-1:0] i_in_data,   // write data
    output logic              o_out_valid, // data available
    input  wire logic         i_out_ready, // reader takes word
    output logic [W-1:0]      o_out_data   // head word
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [CW-1:0]       cnt;
        logic                vld;
        logic                rdy;
        logic [W-1:0]        head;
    } rss_fifo_st_t;

    rss_fifo_st_t r, n;
    logic         push;
    logic         pop;

    // flags and head word are registered copies of the next count and pointer
    assign o_in_ready  = r.rdy;
    assign o_out_valid = r.vld;
    assign o_out_data  = r.head;
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // pointer and count update; depth is a power of two so pointers wrap
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = i_in_data;
            n.wr        = r.wr + 1'b1;
        end
        if (pop) begin
            n.rd = r.rd + 1'b1;
        end
        n.cnt  = r.cnt + CW'(push) - CW'(pop);
        n.vld  = (n.cnt != '0);
        n.rdy  = (n.cnt != FULL_CNT);
        n.head = n.mem[n.rd];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r     <= '0;
            r.rdy <= 1'b1;
        end else begin
            r <= n;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        r.cnt <= FULL_CNT) else $error("fifo count beyond depth");
endmodule

// *** src/rss_top.sv ***
/*
 * Read sync sequencer: freeze/restart sequencing of the oscillator around
 * read request changes, recovered clock selection, preamble detection,
 * retimed data with a small buffer, and the serial control register.
 * Assumes the oscillator arrives on i_osc_clk; all pins but i_data_ready are asynchronous.
 */
`timescale 1ns/1ps
module rss_top
    import rss_pkg::*;
(
    input  wire logic                i_core_clk,            // 40 MHz core clock
    input  wire logic                i_rst_n,               // async reset, low
    input  wire logic                i_osc_clk,             // oscillator clock
    input  wire logic                i_read_req,            // read request pin
    input  wire logic                i_encoded_pulse_in,    // encoded read pulses
    input  wire logic                i_ref_clk_in,          // reference timebase
    input  wire logic [1:0]          i_pattern_sel,         // 0..3 = 1T..4T
    input  wire logic                i_shift_clk,           // control shift clock
    input  wire logic                i_shift_serial_in,     // control shift data
    input  wire logic                i_shift_load_enable_n, // shift enable, low
    input  wire logic                i_data_ready,          // reader takes a bit
    output logic                     o_bit_clk,             // recovered bit clock
    output logic                     o_sync_data,           // retimed data
    output logic                     o_preamble_found,      // latched found flag
    output logic                     o_phase_aligned_restart, // oscillator frozen
    output logic signed [STROBE_W-1:0] o_strobe_offset,     // signed strobe steps
    output logic                     o_test_mode,           // control bit 5
    output logic                     o_data_valid,          // buffered bit ready
    output logic [FIFO_W-1:0]        o_data,                // buffered bit
    output logic                     o_buf_full             // buffer refused a bit
);
    typedef struct packed {
        logic [SYNC_W-1:0]         s1;
        logic [SYNC_W-1:0]         s2;
        logic [SYNC_W-1:0]         s3;
        rss_state_t                state;
        logic [3:0]                cnt;
        logic                      freeze;
        logic                      bit_clk;
        logic                      sync_data;
        logic                      pulse_seen;
        logic [2:0]                gap;
        logic [5:0]                run;
        logic                      pend;
        logic                      found;
        logic [CTL_W-1:0]          ctl;
        logic [STROBE_W-1:0]       strobe;
        logic                      test;
        logic                      full;
    } rss_core_t;

    typedef struct packed {
        logic f1;
        logic f2;
        logic phase;
    } rss_link_t;

    rss_core_t   r, n;
    rss_link_t   lr, ln;
    logic        read_s;
    logic        pulse_rise;
    logic        ref_rise;
    logic        ref_fall;
    logic        shclk_fall;
    logic        fall_evt;
    logic [2:0]  exp_gap;
    logic [2:0]  gap_inc;
    logic [5:0]  run_inc;
    logic        push;
    logic        fifo_in_ready;

    // rising edge of one synchronised input
    function automatic logic rise_of(input logic [SYNC_W-1:0] cur, input logic [SYNC_W-1:0] prv, input int idx);
        return cur[idx] & ~prv[idx];
    endfunction

    // run length needed per pattern
    function automatic logic [5:0] run_need(input logic [1:0] sel);
        case (sel)
            2'h0:    return RUN_1T;
            2'h1:    return RUN_2T;
            2'h2:    return RUN_3T;
            default: return RUN_4T;
        endcase
    endfunction

    // link side: oscillator phase, parked high while frozen so it restarts low
    always_comb begin
        ln       = lr;
        ln.f1    = r.freeze;
        ln.f2    = lr.f1;
        ln.phase = lr.f2 ? 1'b1 : ~lr.phase;
    end

    always_ff @(posedge i_osc_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lr <= '0;
        end else begin
            lr <= ln;
        end
    end

    // decoded events on the second synchroniser stage
    assign read_s     = r.s2[SI_READ];
    assign pulse_rise = rise_of(r.s2, r.s3, SI_PULSE);
    assign ref_rise   = rise_of(r.s2, r.s3, SI_REF);
    assign ref_fall   = rise_of(~r.s2, ~r.s3, SI_REF);
    assign shclk_fall = rise_of(~r.s2, ~r.s3, SI_SHCLK);
    assign exp_gap    = {1'b0, r.s2[SI_SEL +: 2]} + 3'h1;
    assign gap_inc    = (r.gap == 3'h7) ? r.gap : r.gap + 3'h1;
    assign run_inc    = (r.run == RUN_MAX) ? r.run : r.run + 6'h01;

    // core sequencer
    always_comb begin
        n    = r;
        n.s1 = {i_pattern_sel, lr.phase, i_shift_load_enable_n, i_shift_serial_in,
                i_shift_clk, i_ref_clk_in, i_encoded_pulse_in, i_read_req};
        n.s2 = r.s1;
        n.s3 = r.s2;
        case (r.state)
            ST_REF: begin
                n.bit_clk = r.s2[SI_REF];                          // [RQ12]
                n.freeze  = 1'b0;
                if (read_s) begin
                    n.state = ST_WAIT_STOP;
                    n.cnt   = 4'h0;
                end
            end
            ST_WAIT_STOP: begin
                n.bit_clk = r.s2[SI_REF];
                if (!read_s) begin
                    n.state = ST_REF;
                end else if (ref_fall) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == STOP_EDGES - 4'h1) begin          // [RQ1]
                        n.freeze  = 1'b1;
                        n.bit_clk = 1'b1;                          // [RQ4]
                        n.state   = ST_FROZEN_RD;
                        n.cnt     = 4'h0;
                    end
                end
            end
            ST_FROZEN_RD: begin
                n.bit_clk = 1'b1;                                  // [RQ4]
                if (!read_s) begin
                    n.state = ST_ABORT;
                    n.cnt   = 4'h0;
                end else if (pulse_rise) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == RESTART_EDGES - 4'h1) begin       // [RQ2]
                        n.freeze = 1'b0;
                        n.state  = ST_READ;
                        n.gap    = 3'h0;
                        n.run    = 6'h01;
                    end
                end
            end
            ST_READ: begin
                n.bit_clk = r.s2[SI_OSC];
                if (!read_s) begin
                    n.state = ST_ABORT;
                    n.cnt   = 4'h0;
                end
            end
            ST_ABORT: begin
                n.bit_clk = r.s2[SI_OSC];
                if (ref_rise) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == ABORT_EDGES - 4'h1) begin         // [RQ3]
                        n.freeze  = 1'b1;
                        n.bit_clk = 1'b1;                          // [RQ4]
                        n.state   = ST_HOLD_REF;
                        n.cnt     = 4'h0;
                    end
                end
            end
            ST_HOLD_REF: begin
                // restart only on a reference rise so the clock output never glitches low
                n.bit_clk = 1'b1;                                  // [RQ4]
                if (r.cnt != HOLD_CYC) begin
                    n.cnt = r.cnt + 4'h1;
                end else if (ref_rise) begin
                    n.freeze = 1'b0;
                    n.state  = ST_REF;
                end
            end
            default: begin
                n.state  = ST_REF;
                n.freeze = 1'b0;
            end
        endcase

        // every data step and every found and full flag rise is launched from a falling clock edge
        fall_evt = r.bit_clk & ~n.bit_clk;

        // preamble run tracking, read mode only
        if (r.state == ST_READ && read_s) begin
            if (pulse_rise) begin
                n.run = (r.gap == exp_gap) ? run_inc : 6'h01;      // [RQ16]
                n.gap = fall_evt ? 3'h1 : 3'h0;
            end else if (fall_evt) begin
                n.gap = gap_inc;
                if (gap_inc > exp_gap) begin
                    n.run = 6'h00;                                 // [RQ16]
                end
            end
            if (n.run >= run_need(r.s2[SI_SEL +: 2])) begin        // [RQ5] [RQ6] [RQ7] [RQ8]
                n.pend = 1'b1;
            end
            if (fall_evt && r.pend) begin
                n.found = 1'b1;                                    // [RQ9] [RQ15]
            end
        end else if (r.state != ST_FROZEN_RD || !read_s) begin
            n.run   = 6'h00;
            n.pend  = 1'b0;
            n.found = 1'b0;                                        // [RQ17]
        end

        // pulse seen in a cell is launched at the following fall; set wins
        if (fall_evt) begin
            n.sync_data  = (r.state == ST_READ) ? r.pulse_seen : 1'b0; // [RQ11]
            n.pulse_seen = pulse_rise;
        end else if (pulse_rise) begin
            n.pulse_seen = 1'b1;
        end

        // control register ignores clock and data while enable is high
        if (shclk_fall && !r.s2[SI_SHEN]) begin
            n.ctl = {r.ctl[CTL_W-2:0], r.s2[SI_SHDAT]};            // [RQ13]
        end
        n.test = r.ctl[CTL_TEST_BIT];                              // [RQ14]
        if (!read_s) begin
            n.strobe = '0;                                         // [RQ17]
        end else if (r.ctl[CTL_SIGN_BIT]) begin
            n.strobe = STROBE_W'(5'h00 - {1'b0, r.ctl[3:0]});      // [RQ10]
        end else begin
            n.strobe = {1'b0, r.ctl[3:0]};                         // [RQ10]
        end

        // a full buffer drops the bit; the flag tells the reader it fell behind
        n.full = (r.state == ST_READ) & fall_evt & ~fifo_in_ready;
    end

    assign push = (r.state == ST_READ) && r.bit_clk && !n.bit_clk;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r         <= '0;
            r.state   <= ST_REF;
        end else begin
            r <= n;
        end
    end

    rss_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .i_clk       (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (r.pulse_seen),
        .o_out_valid (o_data_valid),
        .i_out_ready (i_data_ready),
        .o_out_data  (o_data)
    );

    // outputs come from the core state flops
    assign o_bit_clk               = r.bit_clk;
    assign o_sync_data             = r.sync_data;
    assign o_preamble_found        = r.found;
    assign o_phase_aligned_restart = r.freeze;
    assign o_strobe_offset         = r.strobe;
    assign o_test_mode             = r.test;
    assign o_buf_full              = r.full;

    sequence s_read_up;
        $rose(read_s) && r.state == ST_REF;
    endsequence

    sequence s_frozen_for_read;
        r.state == ST_FROZEN_RD && r.freeze;
    endsequence

    AST_STOP_FREEZE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ1]
        s_read_up ##1 (read_s && r.state == ST_WAIT_STOP)[*8] |-> (r.cnt < STOP_EDGES))
        else $error("too many falls before freeze");
    AST_RESTART_TWO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ2]
        (r.state == ST_FROZEN_RD && $past(r.state) == ST_FROZEN_RD ##1 r.state == ST_READ)
        |-> $past(pulse_rise) && $past(r.cnt) == RESTART_EDGES - 4'h1)
        else $error("restart not on second pulse");
    AST_ABORT_BOUND: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ3]
        r.state == ST_ABORT |-> r.cnt < ABORT_MAX)
        else $error("abort restart too late");
    AST_REST_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ4]
        s_frozen_for_read |-> r.bit_clk)
        else $error("clock not resting high");
    AST_FOUND_ON_FALL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ9]
        $rose(r.found) |-> $fell(r.bit_clk) && $past(r.pend))
        else $error("found not on clock fall");
    AST_FOUND_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ15]
        r.found && read_s && r.state == ST_READ |=> r.found)
        else $error("found dropped during read");
    AST_IDLE_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ17]
        !read_s ##1 !read_s |-> r.strobe == '0 && !r.found)
        else $error("strobe or found set while idle");
    AST_DATA_ON_FALL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ11]
        $changed(r.sync_data) |-> $fell(r.bit_clk))
        else $error("data moved off clock fall");
    AST_REF_PASS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ12]
        r.state == ST_REF && $past(r.state) == ST_REF |-> r.bit_clk == $past(r.s2[SI_REF]))
        else $error("reference not passed through");
    AST_SHIFT_IGNORED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ13]
        $past(r.s2[SI_SHEN]) |-> $stable(r.ctl))
        else $error("control shifted while disabled");
    AST_RUN_BREAK: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ16]
        r.state == ST_READ && read_s && pulse_rise && r.gap != exp_gap |=> r.run == 6'h01)
        else $error("broken run not restarted");
    AST_NEG_STROBE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RQ10]
        read_s && r.ctl[CTL_SIGN_BIT] && r.ctl[3:0] != 4'h0 |=> r.strobe[STROBE_W-1])
        else $error("sign bit not applied");
endmodule

// *** bench/rss_reader.sv ***
/*
 * Disk controller side model: takes buffered bits and can stall.
 * Assumes it shares the core clock and reset with the sequencer.
 */
`timescale 1ns/1ps
module rss_reader (
    input  wire logic i_clk,   // core clock
    input  wire logic i_rst_n, // async reset, low
    input  wire logic i_stall, // hold off taking bits
    input  wire logic i_valid, // bit available
    input  wire logic i_data,  // head bit
    output logic      o_ready, // take the bit
    output int        o_taken, // bits taken so far
    output int        o_ones   // ones taken so far
);
    // a stalled reader refuses every bit, so the buffer must fill
    assign o_ready = i_rst_n & ~i_stall;
    // count each bit handed over at a rising edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_taken <= 0;
            o_ones  <= 0;
        end else if (i_valid && o_ready) begin
            o_taken <= o_taken + 1;
            o_ones  <= o_ones + int'(i_data);
        end
    end
endmodule

// *** bench/rss_top_tb_top.sv ***
/*
 * Bench for the read sync sequencer: one row per preamble pattern,
 * then hand tests for broken runs, latching and the ignored shift port.
 * Assumes rss_pkg, rss_fifo, rss_top and rss_reader are compiled first.
 */
`timescale 1ns/1ps
module rss_top_tb_top;
    import rss_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic [5:0] ctl;
        logic [4:0] stb;
        logic       tst;
        logic [5:0] nom;
    } rss_row_t;
    logic clk = 0, osc = 0, rst_n = 0, rd = 0, pin = 0, rf = 0;
    logic [1:0] sel = 2'h0;
    logic shc = 1, shd = 0, shen_n = 1, stall = 0, full_seen = 0;
    logic bclk, sdat, found, frz, tmode, dval, dbit, bfull, rdy, pb, ps, pf;
    logic signed [STROBE_W-1:0] strobe;
    logic [2:0] refc = 3'h0;
    int error_cnt = 0, checks_done = 0, taken, falls = 0, tg = 0, ones, sones = 0, o0 = 0, s0 = 0;
    rss_row_t rows [4] = '{'{2'h0, 6'h25, 5'h05, 1'h1, RUN_1T}, '{2'h1, 6'h1F, 5'h11, 1'h0, RUN_2T},
                           '{2'h2, 6'h00, 5'h00, 1'h0, RUN_3T}, '{2'h3, 6'h31, 5'h1F, 1'h1, RUN_4T}};

    // core clock 25 ns; link clock 125 ns with an odd phase offset
    always #12.5 clk = ~clk;
    initial begin
        #3.1;
        forever #62.5 osc = ~osc;
    end
    // reference toggles every four core cycles, driven off the sampling edge
    always @(negedge clk) begin
        refc <= refc + 3'h1;
        if (refc[1:0] == 2'h3) rf <= ~rf;
    end

    rss_top u_rss_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_osc_clk(osc), .i_read_req(rd),
        .i_encoded_pulse_in(pin), .i_ref_clk_in(rf), .i_pattern_sel(sel), .i_shift_clk(shc),
        .i_shift_serial_in(shd), .i_shift_load_enable_n(shen_n), .i_data_ready(rdy), .o_bit_clk(bclk),
        .o_sync_data(sdat), .o_preamble_found(found), .o_phase_aligned_restart(frz),
        .o_strobe_offset(strobe), .o_test_mode(tmode), .o_data_valid(dval), .o_data(dbit), .o_buf_full(bfull));
    rss_reader u_rss_reader (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(dval),
        .i_data(dbit), .o_ready(rdy), .o_taken(taken), .o_ones(ones));

    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic ok(input string nm, input logic c);
        chk(nm, 8'h01, {7'h00, c});
    endtask
    // 0 picks the freeze flag, anything else the buffer valid
    function automatic logic sig(input int w);
        return (w == 0) ? frz : dval;
    endfunction
    task automatic wait_on(input int w, input logic v, input int lim, input string nm);
        for (int i = 0; i < lim && sig(w) !== v; i++) @(negedge clk);
        chk(nm, {7'h00, v}, {7'h00, sig(w)});
        if (sig(w) !== v) summarize();
    endtask
    // wait k recovered clock falls, bounded: a stopped clock ends the run
    task automatic bfall(input int k);
        int t;
        t = falls + k;
        for (int i = 0; i < 400 && falls < t; i++) @(negedge clk);
        ok("bit_clk_runs", falls >= t);
        if (falls < t) summarize();
    endtask
    task automatic pulse();
        pin <= 1;
        repeat (2) @(negedge clk);
        pin <= 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic run(input int n, input int g);
        repeat (n) begin
            bfall(g);
            pulse();
        end
    endtask
    // six bits, msb first, data set while the shift clock is high
    task automatic shift(input logic [5:0] w, input logic en_n);
        shen_n <= en_n;
        for (int i = 5; i >= 0; i--) begin
            shd <= w[i];
            repeat (3) @(negedge clk);
            shc <= 0;
            repeat (3) @(negedge clk);
            shc <= 1;
        end
        repeat (3) @(negedge clk);
        shen_n <= 1;
        @(negedge clk);
    endtask
    task automatic start_read(input logic [1:0] s);
        int f0;
        sel <= s;
        rd <= 1;
        f0 = falls;
        wait_on(0, 1'b1, 80, "freeze");
        ok("stop_falls", (falls - f0) <= 3);
        ok("hold_high", bclk);
        pulse();
        ok("still_frozen", frz);
        pulse();
        wait_on(0, 1'b0, 20, "restart");
    endtask
    task automatic end_read();
        rd <= 0;
        repeat (5) @(negedge clk);
        ok("found_clr", found === 1'b0);
        chk("strobe_clr", 8'h00, {3'h0, strobe});
        wait_on(0, 1'b1, 40, "abort_freeze");
        ok("abort_hold", bclk);
        wait_on(0, 1'b0, 20, "abort_end");
    endtask
    task automatic idle_chk();
        int t0;
        t0 = tg;
        repeat (64) @(negedge clk);
        ok("ref_follow", (tg - t0) >= 15 && (tg - t0) <= 17);
    endtask

    // monitors sample at the falling edge, where registered outputs settle
    always @(negedge clk) begin
        if (rst_n && pb === 1'b1 && bclk === 1'b0) falls++;
        if (rst_n && pb === 1'b1 && bclk === 1'b0 && sdat === 1'b1) sones++;
        if (rst_n && bclk !== pb) tg++;
        if (rst_n && sdat !== ps) ok("sdat_edge", pb === 1'b1 && bclk === 1'b0);
        if (rst_n && found === 1'b1 && pf === 1'b0) ok("found_edge", pb === 1'b1 && bclk === 1'b0);
        if (bfull === 1'b1) full_seen = 1;
        pb <= bclk;
        ps <= sdat;
        pf <= found;
    end

    initial begin
        repeat (8) @(negedge clk);
        chk("rst_out", 8'h00, {1'b0, bclk, sdat, found, frz, tmode, dval, bfull});
        rst_n <= 1;
        repeat (8) @(negedge clk);
        idle_chk();
        // one read per pattern; the first row stalls the reader to fill the buffer
        for (int r = 0; r < 4; r++) begin
            stall <= (r == 0);
            shift(rows[r].ctl, 1'b0);
            chk("test_mode", {7'h00, rows[r].tst}, {7'h00, tmode});
            start_read(rows[r].sel);
            chk("strobe", {3'h0, rows[r].stb}, {3'h0, strobe});
            // extra falls beyond the spacing would break the run, so wait exactly one gap
            run(int'(rows[r].nom) - 3, int'(rows[r].sel) + 1);
            bfall(int'(rows[r].sel) + 1);
            ok("found_early", found === 1'b0);
            pulse();
            run(1, int'(rows[r].sel) + 1);
            bfall(2);
            ok("found", found);
            end_read();
        end
        ok("buf_refused", full_seen);
        // an ignored shift must leave test mode set by the last row
        shift(6'h00, 1'b1);
        ok("shift_ignored", tmode);
        o0 = ones;
        s0 = sones;
        // a broken spacing restarts the run, so 4T needs sixteen more
        start_read(2'h3);
        run(10, 4);
        run(1, 2);
        run(12, 4);
        bfall(4);
        ok("run_restart", found === 1'b0);
        pulse();
        run(2, 4);
        bfall(2);
        ok("found_4t", found);
        repeat (60) @(negedge clk);
        ok("found_latched", found);
        end_read();
        idle_chk();
        wait_on(1, 1'b0, 200, "drain");
        ok("taken", taken >= FIFO_D);
        // two frozen pulses share one cell, then 26 run pulses one cell each
        chk("data_ones", 8'h1B, 8'(ones - o0));
        chk("sync_ones", 8'h1B, 8'(sones - s0));
        summarize();
    end
endmodule
